// ==== core/fcs_consts.vh ====
// Purpose: constants of the flash command sequencer host controller
// Assumes: included by its bare name from the design files
// Notes: command bytes are 8-bit and unlock addresses 11-bit wide, all hexadecimal
`ifndef FCS_CONSTS_VH
`define FCS_CONSTS_VH

// ----------------------------------------------------------------
// register map (byte offsets, one word each)
// ----------------------------------------------------------------
`define FCS_REG_CMD 8'h00
`define FCS_REG_ADDR 8'h04
`define FCS_REG_DATA 8'h08
`define FCS_REG_STAT 8'h0C

// ----------------------------------------------------------------
// command register fields and operation codes
// ----------------------------------------------------------------
`define FCS_CMD_POLL_BIT 8
`define FCS_OP_RESET1 4'h0
`define FCS_OP_RESET3 4'h1
`define FCS_OP_AUTOSEL 4'h2
`define FCS_OP_PROG 4'h3
`define FCS_OP_BYP_ENTER 4'h4
`define FCS_OP_BYP_PROG 4'h5
`define FCS_OP_BYP_EXIT 4'h6
`define FCS_OP_CHIP_ERASE 4'h7
`define FCS_OP_BLK_ERASE 4'h8
`define FCS_OP_BLK_ADD 4'h9
`define FCS_OP_SUSPEND 4'hA
`define FCS_OP_RESUME 4'hB
`define FCS_OP_READ 4'hC

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define FCS_ST_BUSY 0
`define FCS_ST_DONE 1
`define FCS_ST_FAIL 2
`define FCS_ST_REJ 3
`define FCS_ST_BYP 4
`define FCS_ST_SUSP 5
`define FCS_ST_BYTE_LO 8

// ----------------------------------------------------------------
// device command bytes and addresses
// ----------------------------------------------------------------
`define FCS_CMD_ADDR_W 11
`define FCS_A_UNLOCK1 11'h555
`define FCS_A_UNLOCK2 11'h2AA
`define FCS_A_ANY 11'h000
`define FCS_D_UNLOCK1 8'hAA
`define FCS_D_UNLOCK2 8'h55
`define FCS_D_RESET 8'hF0
`define FCS_D_AUTOSEL 8'h90
`define FCS_D_PROG 8'hA0
`define FCS_D_BYP 8'h20
`define FCS_D_BYP_EXIT2 8'h00
`define FCS_D_ERASE_SETUP 8'h80
`define FCS_D_CHIP 8'h10
`define FCS_D_BLK 8'h30
`define FCS_D_SUSPEND 8'hB0
`define FCS_D_RESUME 8'h30

// ----------------------------------------------------------------
// status byte bits and timing
// ----------------------------------------------------------------
`define FCS_SB_ERROR 5
`define FCS_SB_TOGGLE 6
`define FCS_CLK_MHZ 40
`define FCS_PHASE_NS 50

`endif

// ==== core/fcs_tick.v ====
// Purpose: phase enable divider for the flash bus cycles
// Assumes: run low holds the count at zero so phases start aligned
// Notes: tick is a one-cycle pulse every DIV cycles while run is high
`timescale 1ns/1ps
`default_nettype none

module fcs_tick #(
   parameter W = 8,
   parameter [W-1:0] DIV = 2
) (
   input wire hclk,
   input wire hresetn,
   input wire run,
   output reg tick
);

   reg [W-1:0] cnt_q;

   // ----------------------------------------------------------------
   // divider
   // ----------------------------------------------------------------
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= {W{1'b0}};
         tick <= 1'b0;
      end else if (!run) begin
         cnt_q <= {W{1'b0}};
         tick <= 1'b0;
      end else if (cnt_q == DIV - 1'b1) begin
         cnt_q <= {W{1'b0}};
         tick <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 1'b1;
         tick <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// ==== core/fcs_ctrl.v ====
// Purpose: host controller issuing flash command sequences and polling status
// Assumes: AHB-Lite slave with zero wait states; flash pins synchronous to hclk
// Notes: each bus phase lasts one divider tick; software polls busy/done
//
// How it works
// - unlock pair AA at 555, 55 at 2AA
// - F0, alone or after unlock, restores array read
// - unlock then 90 at 555 enters identification
// - program is unlock, A0 at 555, target write
// - bypass: 20 enters, A0+target programs, 90/00 exits
// - chip erase is six writes ending 10
// - error persists until F0 reset clears it
// - block erase ends 30 at block, repeat adds
// - B0 suspends; controller halts within fifteen microseconds
// - 30 resumes; host polls until completion
`timescale 1ns/1ps
`default_nettype none
`include "fcs_consts.vh"

module fcs_ctrl #(
   parameter AW = 17,
   parameter PHASE_CYC = ((`FCS_PHASE_NS * `FCS_CLK_MHZ) + 999) / 1000
) (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg hreadyout,
   output reg hresp,
   output reg [31:0] hrdata,
   output reg [AW-1:0] flash_addr,
   output reg [7:0] flash_dq_out,
   output reg flash_dq_oe,
   input wire [7:0] flash_dq_in,
   output reg flash_ce_n,
   output reg flash_oe_n,
   output reg flash_we_n
);

   localparam [2:0] S_IDLE = 3'd0;
   localparam [2:0] S_WSET = 3'd1;
   localparam [2:0] S_WPUL = 3'd2;
   localparam [2:0] S_WREL = 3'd3;
   localparam [2:0] S_RSET = 3'd4;
   localparam [2:0] S_RWAIT = 3'd5;
   localparam [2:0] S_RREL = 3'd6;
   localparam [7:0] PHASE_DIV = PHASE_CYC[7:0];

   reg [2:0] st_q;
   reg [3:0] op_q;
   reg poll_q;
   reg [2:0] step_q;
   reg [AW-1:0] addr_q;
   reg [7:0] data_q;
   reg [7:0] last_q;
   reg [7:0] prev_q;
   reg have_prev_q;
   reg err_seen_q;
   reg busy_q;
   reg done_q;
   reg fail_q;
   reg rej_q;
   reg byp_q;
   reg susp_q;
   reg ap_wr_q;
   reg [7:0] ap_addr_q;
   wire tick;

   // ----------------------------------------------------------------
   // command sequence tables
   // ----------------------------------------------------------------
   function [2:0] seq_len;
      input [3:0] op;
      begin
         case (op)
            `FCS_OP_RESET1, `FCS_OP_BLK_ADD, `FCS_OP_SUSPEND, `FCS_OP_RESUME: seq_len = 3'd1;
            `FCS_OP_BYP_PROG, `FCS_OP_BYP_EXIT: seq_len = 3'd2;
            `FCS_OP_RESET3, `FCS_OP_AUTOSEL, `FCS_OP_BYP_ENTER: seq_len = 3'd3;
            `FCS_OP_PROG: seq_len = 3'd4;
            `FCS_OP_CHIP_ERASE, `FCS_OP_BLK_ERASE: seq_len = 3'd6;
            default: seq_len = 3'd0;
         endcase
      end
   endfunction

   // {use target address, use target data, command address, command data}
   function [20:0] seq_ent;
      input [3:0] op;
      input [2:0] step;
      reg [7:0] mid;
      begin
         mid = `FCS_D_ERASE_SETUP;
         case (op)
            `FCS_OP_RESET3: mid = `FCS_D_RESET;
            `FCS_OP_AUTOSEL: mid = `FCS_D_AUTOSEL;
            `FCS_OP_PROG: mid = `FCS_D_PROG;
            `FCS_OP_BYP_ENTER: mid = `FCS_D_BYP;
            default: mid = `FCS_D_ERASE_SETUP;
         endcase
         case (op)
            `FCS_OP_RESET1: seq_ent = {2'b00, `FCS_A_ANY, `FCS_D_RESET};
            `FCS_OP_BYP_PROG: begin
               if (step == 3'd0) begin
                  seq_ent = {2'b00, `FCS_A_ANY, `FCS_D_PROG};
               end else begin
                  seq_ent = {2'b11, `FCS_A_ANY, 8'h00};
               end
            end
            `FCS_OP_BYP_EXIT: begin
               if (step == 3'd0) begin
                  seq_ent = {2'b00, `FCS_A_ANY, `FCS_D_AUTOSEL};
               end else begin
                  seq_ent = {2'b00, `FCS_A_ANY, `FCS_D_BYP_EXIT2};
               end
            end
            `FCS_OP_BLK_ADD: seq_ent = {2'b10, `FCS_A_ANY, `FCS_D_BLK};
            `FCS_OP_SUSPEND: seq_ent = {2'b00, `FCS_A_ANY, `FCS_D_SUSPEND};
            `FCS_OP_RESUME: seq_ent = {2'b00, `FCS_A_ANY, `FCS_D_RESUME};
            default: begin
               case (step)
                  3'd0, 3'd3: begin
                     if (step == 3'd3 && op == `FCS_OP_PROG) begin
                        seq_ent = {2'b11, `FCS_A_ANY, 8'h00};
                     end else begin
                        seq_ent = {2'b00, `FCS_A_UNLOCK1, `FCS_D_UNLOCK1};
                     end
                  end
                  3'd1, 3'd4: seq_ent = {2'b00, `FCS_A_UNLOCK2, `FCS_D_UNLOCK2};
                  3'd2: seq_ent = {2'b00, `FCS_A_UNLOCK1, mid};
                  3'd5: begin
                     if (op == `FCS_OP_CHIP_ERASE) begin
                        seq_ent = {2'b00, `FCS_A_UNLOCK1, `FCS_D_CHIP};
                     end else begin
                        seq_ent = {2'b10, `FCS_A_ANY, `FCS_D_BLK};
                     end
                  end
                  default: seq_ent = {2'b00, `FCS_A_ANY, `FCS_D_RESET};
               endcase
            end
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // register access
   // ----------------------------------------------------------------
   wire ap_take = hsel && hready && htrans[1];
   wire [3:0] new_op = hwdata[3:0];
   wire new_byp_op = (new_op == `FCS_OP_BYP_PROG) || (new_op == `FCS_OP_BYP_EXIT);
   wire new_reset = (new_op == `FCS_OP_RESET1) || (new_op == `FCS_OP_RESET3);
   // only reset or plain reads while an error stands; bypass takes its own set
   wire new_legal = (new_op <= `FCS_OP_READ) &&
      (!fail_q || new_reset || new_op == `FCS_OP_READ) &&
      (byp_q ? (new_byp_op || new_op == `FCS_OP_RESET1 || new_op == `FCS_OP_READ)
             : !new_byp_op);
   wire cmd_wr = ap_wr_q && (ap_addr_q == `FCS_REG_CMD);
   wire [20:0] ent = seq_ent(op_q, step_q);
   wire [2:0] len = seq_len(op_q);
   wire [31:0] stat_word = {16'h0000, last_q, 2'b00, susp_q, byp_q, rej_q, fail_q, done_q,
      busy_q};
   reg [31:0] rd_mux;

   always @* begin
      case (haddr[7:0])
         `FCS_REG_CMD: rd_mux = {23'h000000, poll_q, 4'h0, op_q};
         `FCS_REG_ADDR: rd_mux = {{(32-AW){1'b0}}, addr_q};
         `FCS_REG_DATA: rd_mux = {24'h000000, data_q};
         `FCS_REG_STAT: rd_mux = stat_word;
         default: rd_mux = 32'h00000000;
      endcase
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h00000000;
         ap_wr_q <= 1'b0;
         ap_addr_q <= 8'h00;
      end else begin
         ap_wr_q <= ap_take && hwrite;
         if (ap_take) begin
            ap_addr_q <= haddr[7:0];
         end
         if (ap_take && !hwrite) begin
            hrdata <= rd_mux;
         end
      end
   end

   // ----------------------------------------------------------------
   // phase divider
   // ----------------------------------------------------------------
   fcs_tick #(
      .W(8),
      .DIV(PHASE_DIV)
   ) u_tick (
      .hclk(hclk),
      .hresetn(hresetn),
      .run(busy_q),
      .tick(tick)
   );

   // ----------------------------------------------------------------
   // sequencer and status polling
   // ----------------------------------------------------------------
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= S_IDLE;
         op_q <= `FCS_OP_READ;
         poll_q <= 1'b0;
         step_q <= 3'd0;
         addr_q <= {AW{1'b0}};
         data_q <= 8'h00;
         last_q <= 8'h00;
         prev_q <= 8'h00;
         have_prev_q <= 1'b0;
         err_seen_q <= 1'b0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         fail_q <= 1'b0;
         rej_q <= 1'b0;
         byp_q <= 1'b0;
         susp_q <= 1'b0;
         flash_addr <= {AW{1'b0}};
         flash_dq_out <= 8'h00;
         flash_dq_oe <= 1'b0;
         flash_ce_n <= 1'b1;
         flash_oe_n <= 1'b1;
         flash_we_n <= 1'b1;
      end else begin
         if (ap_wr_q && !busy_q && ap_addr_q == `FCS_REG_ADDR) begin
            addr_q <= hwdata[AW-1:0];
         end
         if (ap_wr_q && !busy_q && ap_addr_q == `FCS_REG_DATA) begin
            data_q <= hwdata[7:0];
         end
         if (cmd_wr && !busy_q) begin
            done_q <= 1'b0;
            if (new_legal) begin
               rej_q <= 1'b0;
               op_q <= new_op;
               poll_q <= hwdata[`FCS_CMD_POLL_BIT];
               busy_q <= 1'b1;
               step_q <= 3'd0;
               have_prev_q <= 1'b0;
               err_seen_q <= 1'b0;
               if (new_reset) begin
                  fail_q <= 1'b0;
               end
               st_q <= (seq_len(new_op) == 3'd0) ? S_RSET : S_WSET;
            end else begin
               rej_q <= 1'b1;
            end
         end
         if (busy_q && tick) begin
            case (st_q)
               S_WSET: begin
                  // command cycles carry only the low address bits
                  flash_addr <= ent[20] ? addr_q : {{(AW-11){1'b0}}, ent[18:8]};
                  flash_dq_out <= ent[19] ? data_q : ent[7:0];
                  flash_dq_oe <= 1'b1;
                  flash_ce_n <= 1'b0;
                  st_q <= S_WPUL;
               end
               S_WPUL: begin
                  flash_we_n <= 1'b0;
                  st_q <= S_WREL;
               end
               S_WREL: begin
                  flash_we_n <= 1'b1;
                  flash_ce_n <= 1'b1;
                  if (step_q == len - 3'd1) begin
                     st_q <= poll_q ? S_RSET : S_IDLE;
                  end else begin
                     step_q <= step_q + 3'd1;
                     st_q <= S_WSET;
                  end
               end
               S_RSET: begin
                  flash_dq_oe <= 1'b0;
                  flash_addr <= addr_q;
                  flash_ce_n <= 1'b0;
                  flash_oe_n <= 1'b0;
                  st_q <= S_RWAIT;
               end
               S_RWAIT: begin
                  last_q <= flash_dq_in;
                  flash_ce_n <= 1'b1;
                  flash_oe_n <= 1'b1;
                  st_q <= S_RREL;
               end
               S_RREL: begin
                  if (op_q == `FCS_OP_READ) begin
                     st_q <= S_IDLE;
                  end else if (!have_prev_q) begin
                     have_prev_q <= 1'b1;
                     prev_q <= last_q;
                     st_q <= S_RSET;
                  end else if (prev_q[`FCS_SB_TOGGLE] == last_q[`FCS_SB_TOGGLE]) begin
                     st_q <= S_IDLE;
                  end else if (last_q[`FCS_SB_ERROR] && err_seen_q) begin
                     fail_q <= 1'b1;
                     st_q <= S_IDLE;
                  end else begin
                     err_seen_q <= last_q[`FCS_SB_ERROR];
                     prev_q <= last_q;
                     st_q <= S_RSET;
                  end
               end
               default: st_q <= S_IDLE;
            endcase
         end
         if (busy_q && tick && (st_q == S_IDLE || (st_q == S_WREL && step_q == len - 3'd1 &&
               !poll_q))) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
            flash_dq_oe <= 1'b0;
            if (op_q == `FCS_OP_BYP_ENTER) begin
               byp_q <= 1'b1;
            end
            if (op_q == `FCS_OP_BYP_EXIT) begin
               byp_q <= 1'b0;
            end
            if (op_q == `FCS_OP_SUSPEND) begin
               susp_q <= 1'b1;
            end
            if (op_q == `FCS_OP_RESUME) begin
               susp_q <= 1'b0;
            end
         end
      end
   end

endmodule

`default_nettype wire

// ==== sim/fcs_ctrl_assertions.sv ====
// Purpose: port checks for fcs_ctrl
// Assumes: bench program data avoids AA, 55, 10, 80 and 00
// Notes: last flash write is kept to check command order
`timescale 1ns/1ps
`default_nettype none
module fcs_chk #(
   parameter AW = 17,
   parameter PHASE_CYC = 2
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [AW-1:0] flash_addr,
   input wire logic [7:0] flash_dq_out,
   input wire logic flash_dq_oe,
   input wire logic flash_ce_n,
   input wire logic flash_oe_n,
   input wire logic flash_we_n
);
   // ----
   // last write on the flash pins
   // ----
   logic we_q;
   logic [AW-1:0] la_q;
   logic [7:0] ld_q;
   wire fal = we_q && !flash_we_n;
   wire [AW-1:0] a555 = {{(AW-11){1'b0}}, 11'h555};
   wire [AW-1:0] a2aa = {{(AW-11){1'b0}}, 11'h2AA};
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         we_q <= 1'b1;
         la_q <= '0;
         ld_q <= 8'h00;
      end else begin
         we_q <= flash_we_n;
         if (fal) begin
            la_q <= flash_addr;
            ld_q <= flash_dq_out;
         end
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ----
   // checks
   // ----
   property p_okay; hreadyout && !hresp; endproperty
   a_okay: assert property (p_okay) else $error("slave not ready");
   property p_wr_pins; !flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe; endproperty
   a_wr_pins: assert property (p_wr_pins) else $error("bad write pins");
   property p_rd_pins; !flash_oe_n |-> !flash_ce_n && flash_we_n && !flash_dq_oe; endproperty
   a_rd_pins: assert property (p_rd_pins) else $error("bad read pins");
   property p_we_pulse; fal |-> ##[1:8] flash_we_n; endproperty
   a_we_pulse: assert property (p_we_pulse) else $error("write strobe stuck");
   property p_wr_hold; $rose(flash_we_n) |-> $stable(flash_addr) && $stable(flash_dq_out);
   endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write not held");
   property p_unlock; fal && flash_dq_out == 8'hAA |-> flash_addr == a555; endproperty
   a_unlock: assert property (p_unlock) else $error("first unlock address");
   property p_unlock2; fal && flash_dq_out == 8'h55 |-> flash_addr == a2aa && ld_q == 8'hAA;
   endproperty
   a_unlock2: assert property (p_unlock2) else $error("second unlock order");
   property p_setup; fal && flash_dq_out == 8'h80 |-> flash_addr == a555 && ld_q == 8'h55;
   endproperty
   a_setup: assert property (p_setup) else $error("erase setup order");
   property p_chip; fal && flash_dq_out == 8'h10 |-> flash_addr == a555 && la_q == a2aa;
   endproperty
   a_chip: assert property (p_chip) else $error("chip erase order");
   property p_byexit; fal && flash_dq_out == 8'h00 |-> ld_q == 8'h90; endproperty
   a_byexit: assert property (p_byexit) else $error("bypass exit order");
endmodule
bind fcs_ctrl fcs_chk #(.AW(AW), .PHASE_CYC(PHASE_CYC)) u_fcs_chk (
   .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
   .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
   .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n)
);
`default_nettype wire

// ==== sim/fcs_flash_model.sv ====
// Purpose: behavioural flash device facing fcs_ctrl
// Assumes: pins sampled on hclk; no protected blocks
// Notes: busy, window and erase spans shortened to cycles
`timescale 1ns/1ps
`default_nettype none
module fcs_flash_model #(
   parameter AW = 17,
   parameter [7:0] PROT = 8'h00,
   parameter [7:0] MAKER = 8'h5C, // arbitrary
   parameter [7:0] DEVICE = 8'hA3 // arbitrary
) (
   input wire logic hclk,
   input wire logic [AW-1:0] a,
   input wire logic [7:0] d,
   output logic [7:0] q,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n
);
   logic [7:0] mem [0:(1<<AW)-1];
   logic [7:0] blk = 8'h00, last = 8'h00, rd;
   logic we_q = 1'b1, oe_q = 1'b1, byp = 0, ids = 0, err = 0, perr = 0;
   logic susp = 0, pd7 = 0, tog = 0, alt = 0;
   int step = 0, pc = 0, ec = 0, win = 0;
   wire [10:0] c = a[10:0];
   wire inb = blk[a >> 14];
   wire prg = pc > 0;
   wire ers = (ec > 0 || win > 0) && !susp;
   wire stm = prg || ers || err;
   assign q = (!ce_n && !oe_n) ? rd : ~last;
   initial for (int k = 0; k < (1 << AW); k++) mem[k] = 8'hFF;
   always @* begin
      if (ids) rd = a[0] ? DEVICE : MAKER;
      else if (stm) rd = {prg && !pd7, tog, err, 1'b0, win == 0, alt, 2'b00};
      else if (susp && inb) rd = {5'b10001, alt, 2'b00};
      else rd = mem[a];
   end
   // ----
   // bus cycles and internal controller, timed by the local clock
   // ----
   always @(posedge hclk) begin
      we_q <= we_n;
      oe_q <= oe_n;
      if (!oe_n) last <= rd;
      if (oe_n && !oe_q) begin
         tog <= tog ^ stm;
         alt <= alt ^ (inb && (stm || susp));
      end
      if (pc == 1) err <= perr;
      if (pc > 0) pc <= pc - 1;
      if (!susp && win > 0) win <= win - 1;
      else if (!susp && ec > 0) begin
         ec <= ec - 1;
         if (ec == 1) begin
            for (int k = 0; k < (1 << AW); k++) begin
               if (blk[k >> 14] && !PROT[k >> 14]) mem[k] = 8'hFF;
            end
            blk <= 8'h00;
         end
      end
      if (we_q && !we_n && !ce_n && !(prg || ers && blk == 8'hFF)) begin
         if (ers) begin
            if (d == 8'hB0) susp <= 1'b1;
            if (d == 8'hF0) ec <= 0;
            if (d == 8'hF0) win <= 0;
            if (d == 8'h30 && win > 0) blk[a >> 14] <= 1'b1;
            if (d == 8'h30 && win > 0) win <= 40;
         end else if (step == 6) begin
            pd7 <= d[7];
            perr <= (mem[a] & d) != d;
            mem[a] = mem[a] & d;
            pc <= 60;
            step <= 0;
         end else if (d == 8'hF0) begin
            step <= 0;
            ids <= 1'b0;
            err <= 1'b0;
         end else if (byp) begin
            step <= d == 8'hA0 ? 6 : d == 8'h90 ? 7 : 0;
            if (step == 7 && d == 8'h00) byp <= 1'b0;
         end else if (susp && d == 8'h30) begin
            susp <= 1'b0;
            win <= 0;
         end else begin
            step <= 0;
            case (step)
               0: if (c == 11'h555 && d == 8'hAA) step <= 1;
               1: if (c == 11'h2AA && d == 8'h55) step <= 2;
               3: if (c == 11'h555 && d == 8'hAA) step <= 4;
               4: if (c == 11'h2AA && d == 8'h55) step <= 5;
               2: if (c == 11'h555) begin
                  ids <= d == 8'h90;
                  byp <= d == 8'h20;
                  step <= d == 8'hA0 ? 6 : d == 8'h80 ? 3 : 0;
               end
               5: if (d == 8'h30 || c == 11'h555 && d == 8'h10) begin
                  blk <= d == 8'h10 ? 8'hFF : 8'h01 << (a >> 14);
                  win <= d == 8'h30 ? 40 : 0;
                  ec <= 200;
               end
               default: ;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ==== sim/fcs_ctrl_tb.sv ====
// Purpose: self-checking bench for fcs_ctrl with a flash model
// Assumes: one clock at 40 MHz, zero-wait bus slave
// Notes: one-cycle flash phases; device spans shortened in the model
`timescale 1ns/1ps
`default_nettype none
module fcs_ctrl_tb;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, st;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'b010;
   wire hready, hresp, dq_oe, ce_n, oe_n, we_n;
   wire [31:0] hrdata;
   wire [16:0] fa;
   wire [7:0] dq_o, dq_i;
   int error_cnt = 0, total_checks = 0;
   always #12.5 hclk = ~hclk;
   fcs_ctrl #(.AW(17), .PHASE_CYC(1)) i_fcs_ctrl (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
      .hrdata(hrdata), .flash_addr(fa), .flash_dq_out(dq_o), .flash_dq_oe(dq_oe),
      .flash_dq_in(dq_i), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n));
   fcs_flash_model #(.AW(17)) i_fcs_flash_model (.hclk(hclk), .a(fa), .d(dq_o), .q(dq_i),
      .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n));
   // ----
   // bus tasks
   // ----
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      st = hrdata;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic op(input logic [3:0] o, input logic p);
      int n;
      n = 0;
      xfer(1'b1, 32'h00, {23'h0, p, 4'h0, o});
      do begin
         xfer(1'b0, 32'h0C, 32'h0);
         n++;
      end while (st[0] !== 1'b0 && n < 4000);
      chk(st & 32'h1, 32'h0);
   endtask
   task automatic ld(input logic [31:0] a, input logic [31:0] d);
      xfer(1'b1, 32'h04, a);
      xfer(1'b1, 32'h08, d);
   endtask
   task automatic rdb(input logic [31:0] a);
      xfer(1'b1, 32'h04, a);
      op(4'hC, 1'b0);
   endtask
   task automatic complete_run;
      if (error_cnt == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #2000000;
      error_cnt++;
      complete_run;
   end
   // ----
   // tests
   // ----
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      xfer(1'b0, 32'h0C, 32'h0);
      chk(st, 32'h0);
      xfer(1'b0, 32'h00, 32'h0);
      chk(st, 32'h0000_000C);
      xfer(1'b0, 32'h10, 32'h0);
      chk(st, 32'h0);
      ld(32'h123, 32'h5A);
      op(4'h3, 1'b1);
      chk(st & 32'hFF, 32'h02);
      rdb(32'h123);
      chk(st & 32'hFF06, 32'h5A02);
      ld(32'h123, 32'hFF);
      op(4'h3, 1'b1);
      chk(st & 32'hFF, 32'h06);
      op(4'h3, 1'b0);
      chk(st & 32'h0F, 32'h0C);
      op(4'h0, 1'b0);
      rdb(32'h123);
      chk(st & 32'hFF06, 32'h5A02);
      op(4'h2, 1'b0);
      rdb(32'h0);
      chk(st & 32'hFF00, 32'h5C00);
      op(4'h0, 1'b0);
      op(4'h4, 1'b0);
      chk(st & 32'h10, 32'h10);
      ld(32'h200, 32'h3C);
      op(4'h5, 1'b1);
      op(4'h3, 1'b0);
      chk(st & 32'h0F, 32'h08);
      op(4'h6, 1'b0);
      rdb(32'h200);
      chk(st & 32'hFF16, 32'h3C02);
      op(4'h7, 1'b0);
      rdb(32'h200);
      chk(st & 32'hA800, 32'h0800);
      op(4'h1, 1'b1);
      rdb(32'h200);
      chk(st & 32'hFF06, 32'hFF02);
      for (int i = 0; i < 3; i++) begin
         ld(32'h10 + 32'h4000 * i, 32'h21 + 32'h11 * i);
         op(4'h3, 1'b1);
      end
      ld(32'h4010, 32'h0);
      op(4'h8, 1'b0);
      ld(32'h8010, 32'h0);
      op(4'h9, 1'b0);
      op(4'hA, 1'b0);
      chk(st & 32'h20, 32'h20);
      rdb(32'h4010);
      chk(st & 32'hA800, 32'h8800);
      rdb(32'h10);
      chk(st & 32'hFF00, 32'h2100);
      ld(32'h8010, 32'h0);
      op(4'hB, 1'b1);
      chk(st & 32'h26, 32'h02);
      for (int i = 0; i < 3; i++) begin
         rdb(32'h10 + 32'h4000 * i);
         chk(st & 32'hFF00, i == 0 ? 32'h2100 : 32'hFF00);
      end
      complete_run;
   end
endmodule
`default_nettype wire
